// *** hw/clfu_top.sv ***
// cache line flush unit: direct-mapped d-cache flush and i-cache invalidate
//
// Register access over AHB-Lite and the register addresses are this design's own decisions.
`timescale 1ns/1ps
// Operation
// - data flushes use base value plus sign-extended 16-bit offset as the address.
// - the index-only data flush picks the line from the line field only, no hit test.
// - the index-only data flush writes a dirty line back whatever its tag.
// - a line is dirty when a word was modified and not yet written to memory.
// - the tag-checked flush compares stored tag and does nothing on a mismatch.
// - the tag-checked flush writes back only a dirty line whose tag matches.
// - a data flush without fault or tag miss ends by clearing the line valid bit after any write-back.
// - without a data cache the index-only flush does nothing.
// - only the tag-checked flush raises supervisor, TLB and MPU faults.
// - the instruction flush picks the line from the base byte address and invalidates it.
// - without an instruction cache the instruction flush does nothing.
// - the data cache is direct mapped, address split into tag and line fields.
module clfu_top #(
  parameter int LINE_W = 6,
  parameter int IDX_LO = 4,
  parameter int TAG_W = 22,
  parameter int ILINE_W = 6,
  parameter bit HAS_DCACHE = 1'b1,
  parameter bit HAS_ICACHE = 1'b1
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // data cache tag store hooks: line fills, dirty marking by the processor, fault input
  input wire logic mark_dirty,
  input wire logic [LINE_W-1:0] mark_line,
  input wire logic fill_valid,
  input wire logic [LINE_W-1:0] fill_line,
  input wire logic [TAG_W-1:0] fill_tag,
  input wire logic [clfu_pkg::FLT_W-1:0] fault_in,
  // write-back data master handshake
  output logic wb_req,
  output logic [31:0] wb_addr,
  input wire logic wb_ack,
  // interrupt
  output logic irq
);
  // ==========
  // state bank and address split
  localparam int NL = 1 << LINE_W;
  localparam int NI = 1 << ILINE_W;
  typedef struct packed {
    logic [31:0] base;
    logic [15:0] offs;
    logic [1:0] op;
    logic priv;
    clfu_pkg::clfu_state_t st;
    logic [31:0] ea;
    logic [LINE_W-1:0] line;
    logic [NL-1:0] dvalid;
    logic [NL-1:0] ddirty;
    logic [NI-1:0] ivalid;
    logic [clfu_pkg::IRQ_W-1:0] irqs;
    logic [clfu_pkg::IRQ_W-1:0] mask;
    logic [clfu_pkg::FLT_W-1:0] fault;
    logic dph;
    logic dwr;
    logic [7:0] dadr;
    logic [31:0] rdata;
    logic wbreq;
    logic [31:0] wbaddr;
    logic irq;
  } clfu_regs_t;

  clfu_regs_t r_reg;
  clfu_regs_t r_next;
  logic [TAG_W-1:0] tag_mem [NL];
  logic [31:0] ea_c;
  logic [LINE_W-1:0] ln_c;
  logic hit_c;
  logic ahb_go;

  // effective address: base plus sign-extended offset
  assign ea_c = r_reg.base + {{(32-clfu_pkg::OFFSET_W){r_reg.offs[15]}}, r_reg.offs};
  assign ln_c = r_reg.ea[IDX_LO +: LINE_W]; // direct-mapped line field
  assign hit_c = r_reg.dvalid[ln_c] && (tag_mem[ln_c] == r_reg.ea[IDX_LO+LINE_W +: TAG_W]);
  assign ahb_go = hsel && hready && htrans[1];

  // ==========
  // tag store
  // i-cache fills arrive from the fetch side, so here ivalid only ever loses bits
  // tag store is plain memory written on fills; the flush only touches valid and dirty bits
  always_ff @(posedge hclk)
  begin
    if (fill_valid)
    begin
      tag_mem[fill_line] <= fill_tag;
    end
  end

  // ==========
  // register read path
  // register read mux shared by the bus data phase
  function automatic logic [31:0] rd_mux(input clfu_regs_t s, input logic [7:0] a);
    logic [31:0] v;
    v = clfu_pkg::WORD_ZERO;
    unique case (a)
      clfu_pkg::OFF_BASE: v = s.base;
      clfu_pkg::OFF_OFFS: v = {16'h0000, s.offs};
      clfu_pkg::OFF_STAT: v = {30'h0000_0000, s.st};
      clfu_pkg::OFF_IRQS: v = {28'h000_0000, s.irqs};
      clfu_pkg::OFF_MASK: v = {28'h000_0000, s.mask};
      clfu_pkg::OFF_FAULT: v = {28'h000_0000, s.fault};
      clfu_pkg::OFF_CFG: v = {30'h0000_0000, HAS_ICACHE, HAS_DCACHE};
      clfu_pkg::OFF_LINE: v = {{(32-LINE_W){1'b0}}, s.line};
      clfu_pkg::OFF_EA: v = s.ea;
      default: v = clfu_pkg::WORD_ZERO;
    endcase
    return v;
  endfunction

  // ==========
  // next-state logic
  // next-state logic: bus slave, sequencer, interrupts
  always_comb
  begin
    logic [clfu_pkg::IRQ_W-1:0] ev;
    logic start;
    ev = '0;
    start = 1'b0;
    r_next = r_reg;
    // dirty marking by processor stores
    if (mark_dirty)
    begin
      r_next.ddirty[mark_line] = 1'b1;
    end
    if (fill_valid)
    begin
      r_next.dvalid[fill_line] = 1'b1;
      r_next.ddirty[fill_line] = 1'b0;
    end
    // bus address phase latch
    r_next.dph = ahb_go;
    if (ahb_go)
    begin
      r_next.dwr = hwrite;
      r_next.dadr = haddr[7:0];
    end
    // data phase: writes and reads complete with zero wait states
    if (r_reg.dph && r_reg.dwr)
    begin
      unique case (r_reg.dadr)
        // go counts only while idle, so a stray write cannot retarget a running flush
        clfu_pkg::OFF_CTRL: start = hwdata[clfu_pkg::CTRL_GO] && (r_reg.st == clfu_pkg::ST_IDLE);
        clfu_pkg::OFF_BASE: r_next.base = hwdata;
        clfu_pkg::OFF_OFFS: r_next.offs = hwdata[15:0];
        clfu_pkg::OFF_MASK: r_next.mask = hwdata[clfu_pkg::IRQ_W-1:0];
        default: r_next.base = r_reg.base;
      endcase
      if (start)
      begin
        r_next.op = hwdata[clfu_pkg::CTRL_OP_LO +: 2];
        r_next.priv = hwdata[clfu_pkg::CTRL_PRIV];
      end
    end
    // read-to-clear of the sticky status; new events below win
    if (ahb_go && !hwrite && haddr[7:0] == clfu_pkg::OFF_IRQS)
    begin
      r_next.irqs = '0;
    end
    if (ahb_go && !hwrite)
    begin
      r_next.rdata = rd_mux(r_reg, haddr[7:0]);
    end
    // flush sequencer
    unique case (r_reg.st)
      clfu_pkg::ST_IDLE:
      begin
        if (start)
        begin
          r_next.fault = '0;
          r_next.ea = ea_c;
          if (hwdata[clfu_pkg::CTRL_OP_LO +: 2] == clfu_pkg::OP_ILINE)
          begin
            r_next.ea = r_reg.base; // uses the base byte address only
          end
          r_next.st = clfu_pkg::ST_LOOK;
        end
      end
      clfu_pkg::ST_LOOK:
      begin
        r_next.line = ln_c;
        r_next.st = clfu_pkg::ST_IDLE;
        ev[clfu_pkg::IRQ_DONE] = 1'b1;
        if (r_reg.op == clfu_pkg::OP_ILINE)
        begin
          if (HAS_ICACHE)
          begin
            r_next.ivalid[r_reg.ea[IDX_LO +: ILINE_W]] = 1'b0;
          end
        end
        else if (r_reg.op == clfu_pkg::OP_DADDR && ((fault_in | {3'h0, r_reg.priv}) != '0))
        begin
          r_next.fault = fault_in | {3'h0, r_reg.priv};
          ev[clfu_pkg::IRQ_EXC] = 1'b1;
        end
        else if (!HAS_DCACHE || (r_reg.op == clfu_pkg::OP_DADDR && !hit_c))
        begin
          r_next.line = r_reg.line; // no cache effect, line register kept; only done is raised
        end
        else if (r_reg.ddirty[ln_c])
        begin
          r_next.wbreq = 1'b1;
          r_next.wbaddr = {r_reg.ea[31:IDX_LO], {IDX_LO{1'b0}}};
          if (r_reg.op == clfu_pkg::OP_DLINE)
          begin
            r_next.wbaddr = {tag_mem[ln_c], ln_c, {IDX_LO{1'b0}}};
          end
          r_next.st = clfu_pkg::ST_WB;
          ev[clfu_pkg::IRQ_DONE] = 1'b0;
        end
        else
        begin
          r_next.st = clfu_pkg::ST_CLR;
          ev[clfu_pkg::IRQ_DONE] = 1'b0;
        end
      end
      clfu_pkg::ST_WB:
      begin
        if (wb_ack)
        begin
          r_next.wbreq = 1'b0;
          r_next.ddirty[r_reg.line] = 1'b0;
          ev[clfu_pkg::IRQ_WB] = 1'b1;
          r_next.st = clfu_pkg::ST_CLR;
        end
      end
      clfu_pkg::ST_CLR:
      begin
        r_next.dvalid[r_reg.line] = 1'b0;
        r_next.ddirty[r_reg.line] = 1'b0;
        ev[clfu_pkg::IRQ_DONE] = 1'b1;
        r_next.st = clfu_pkg::ST_IDLE;
      end
    endcase
    r_next.irqs = r_next.irqs | ev;
    r_next.irq = |(r_next.irqs & r_reg.mask);
  end

  // ==========
  // state register and outputs
  // single register bank; ivalid and dvalid start empty
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      r_reg <= '0;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  assign hrdata = r_reg.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign wb_req = r_reg.wbreq;
  assign wb_addr = r_reg.wbaddr;
  assign irq = r_reg.irq;

  // ==========
  // assertions
  // write-back request holds still until accepted
  a_wb_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    r_reg.wbreq && !wb_ack |=> r_reg.wbreq && $stable(r_reg.wbaddr))
    else $error("write-back dropped before ack");
  // a pending write-back keeps the sequencer busy
  a_busy_wb: assert property (@(posedge hclk) disable iff (!hresetn)
    r_reg.wbreq |-> r_reg.st == clfu_pkg::ST_WB)
    else $error("write-back pending outside the write-back step");
  // clear step follows ack
  a_clr_after: assert property (@(posedge hclk) disable iff (!hresetn)
    r_reg.st == clfu_pkg::ST_WB && wb_ack
    |=> r_reg.st == clfu_pkg::ST_CLR ##1 !r_reg.dvalid[$past(r_reg.line)])
    else $error("valid not cleared after write-back");
  // the clear step always retires the flush with done set
  a_clr_ends: assert property (@(posedge hclk) disable iff (!hresetn)
    r_reg.st == clfu_pkg::ST_CLR
    |=> r_reg.st == clfu_pkg::ST_IDLE && r_reg.irqs[clfu_pkg::IRQ_DONE])
    else $error("clear step did not retire the flush");
  // a processor store marks its line dirty
  a_dirty_mark: assert property (@(posedge hclk) disable iff (!hresetn)
    mark_dirty && !fill_valid && r_reg.st == clfu_pkg::ST_IDLE
    |=> r_reg.ddirty[$past(mark_line)])
    else $error("store did not mark line dirty");
  // a clean line is never written back
  a_clean_quiet: assert property (@(posedge hclk) disable iff (!hresetn)
    r_reg.st == clfu_pkg::ST_LOOK && !r_reg.ddirty[ln_c] |=> !r_reg.wbreq)
    else $error("clean line written back");
  // tag mismatch leaves no write-back
  a_miss_quiet: assert property (@(posedge hclk) disable iff (!hresetn)
    r_reg.st == clfu_pkg::ST_LOOK && r_reg.op == clfu_pkg::OP_DADDR && !hit_c
    |=> !r_reg.wbreq)
    else $error("write-back on tag miss");
  // tag-checked flush writes back only a dirty hit
  a_tag_wb: assert property (@(posedge hclk) disable iff (!hresetn)
    r_reg.st == clfu_pkg::ST_LOOK && r_reg.op == clfu_pkg::OP_DADDR
    && !(hit_c && r_reg.ddirty[ln_c]) |=> !r_reg.wbreq)
    else $error("tag-checked write-back without dirty hit");
  // index flush writes dirty line back
  a_dirty_wb: assert property (@(posedge hclk) disable iff (!hresetn)
    r_reg.st == clfu_pkg::ST_LOOK && r_reg.op == clfu_pkg::OP_DLINE && r_reg.ddirty[ln_c]
    && HAS_DCACHE |=> r_reg.wbreq)
    else $error("dirty line not written back");
  // index flush never faults
  a_no_fault: assert property (@(posedge hclk) disable iff (!hresetn)
    r_reg.st == clfu_pkg::ST_LOOK && r_reg.op == clfu_pkg::OP_DLINE
    |=> !r_reg.irqs[clfu_pkg::IRQ_EXC] || $past(r_reg.irqs[clfu_pkg::IRQ_EXC]))
    else $error("index flush raised fault");
  // a fault on the tag-checked flush is flagged and recorded
  a_fault_raise: assert property (@(posedge hclk) disable iff (!hresetn)
    r_reg.st == clfu_pkg::ST_LOOK && r_reg.op == clfu_pkg::OP_DADDR && fault_in != '0
    |=> r_reg.irqs[clfu_pkg::IRQ_EXC] && ((r_reg.fault & $past(fault_in)) == $past(fault_in)))
    else $error("tag-checked flush fault not raised");
  // address formation
  a_ea_form: assert property (@(posedge hclk) disable iff (!hresetn)
    r_reg.st == clfu_pkg::ST_IDLE
    ##1 r_reg.st == clfu_pkg::ST_LOOK && r_reg.op != clfu_pkg::OP_ILINE
    |-> r_reg.ea == $past(ea_c))
    else $error("effective address wrong");
  // icache line invalidated
  a_ilin_inv: assert property (@(posedge hclk) disable iff (!hresetn)
    r_reg.st == clfu_pkg::ST_LOOK && r_reg.op == clfu_pkg::OP_ILINE
    |=> !r_reg.ivalid[$past(r_reg.ea[IDX_LO +: ILINE_W])])
    else $error("icache line still valid");
  // icache line comes from the base byte address
  a_iline_pick: assert property (@(posedge hclk) disable iff (!hresetn)
    r_reg.st == clfu_pkg::ST_LOOK && r_reg.op == clfu_pkg::OP_ILINE
    |=> r_reg.line == $past(r_reg.base[IDX_LO +: LINE_W]))
    else $error("icache line not taken from base");
  // interrupt follows status under the mask of the cycle before
  a_irq_level: assert property (@(posedge hclk) disable iff (!hresetn)
    r_reg.irq == |(r_reg.irqs & $past(r_reg.mask)))
    else $error("irq level wrong");
endmodule

// *** hw/clfu_pkg.sv ***
// package: constants, types and register map of the cache line flush unit
package clfu_pkg;
  // register byte offsets on the AHB-Lite slave
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_BASE = 8'h04;
  localparam logic [7:0] OFF_OFFS = 8'h08;
  localparam logic [7:0] OFF_STAT = 8'h0C;
  localparam logic [7:0] OFF_IRQS = 8'h10;
  localparam logic [7:0] OFF_MASK = 8'h14;
  localparam logic [7:0] OFF_FAULT = 8'h18;
  localparam logic [7:0] OFF_CFG = 8'h1C;
  localparam logic [7:0] OFF_LINE = 8'h20;
  localparam logic [7:0] OFF_EA = 8'h24;
  localparam logic [7:0] OFF_SETUP = 8'h28;
  // ctrl field positions
  localparam int CTRL_GO = 0;
  localparam int CTRL_OP_LO = 1;
  localparam int CTRL_PRIV = 3;
  // irq bit positions
  localparam int IRQ_DONE = 0;
  localparam int IRQ_EXC = 1;
  localparam int IRQ_WB = 2;
  localparam int IRQ_W = 3;
  // fault bit positions in the fault input and fault register
  localparam int FLT_SUPV = 0;
  localparam int FLT_FTLB = 1;
  localparam int FLT_DTLB = 2;
  localparam int FLT_MPU = 3;
  localparam int FLT_W = 4;
  localparam int OFFSET_W = 16;
  localparam int HTRANS_NONSEQ = 2;
  localparam logic [1:0] HTRANS_IDLE = 2'h0;
  localparam logic [1:0] HTRANS_NSQ = 2'h2;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  // flush operations
  typedef enum logic [1:0] {
    OP_DLINE = 2'h0,
    OP_DADDR = 2'h1,
    OP_ILINE = 2'h2
  } clfu_op_t;
  // sequencer states, gray along idle-look-write-clear
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_LOOK = 2'h1,
    ST_WB = 2'h3,
    ST_CLR = 2'h2
  } clfu_state_t;
endpackage

// *** verif/clfu_mem_model.sv ***
// backing memory model that accepts write-backs from the flush unit
`timescale 1ns/1ps
// ==========
// memory model
module clfu_mem_model (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // write-back handshake
  input wire logic wb_req,
  input wire logic [31:0] wb_addr,
  output logic wb_ack,
  // stall length and record of accepted write-backs
  input wire logic [3:0] lat,
  output logic [31:0] last_addr,
  output logic [31:0] wb_count
);
  logic [3:0] wait_cnt;
  // a slow answer keeps the request standing for lat+1 cycles before the ack pulse
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wb_ack <= 1'b0;
      wait_cnt <= 4'h0;
      last_addr <= 32'h0000_0000;
      wb_count <= 32'h0000_0000;
    end
    else
    begin
      wb_ack <= 1'b0;
      if (wb_req && !wb_ack && wait_cnt == lat)
      begin
        wb_ack <= 1'b1;
        wait_cnt <= 4'h0;
        last_addr <= wb_addr; // address taken with the accept
        wb_count <= wb_count + 32'h0000_0001;
      end
      else if (wb_req && !wb_ack)
      begin
        wait_cnt <= wait_cnt + 4'h1;
      end
    end
  end
endmodule

// *** verif/tb.sv ***
// self-checking bench of the cache line flush unit
`timescale 1ns/1ps
// ==========
// bench top
module tb;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic mark_dirty = 1'b0, fill_valid = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [3:0] fault_in = 4'h0, lat = 4'h0;
  logic [5:0] mark_line = 6'h00, fill_line = 6'h00;
  logic [21:0] fill_tag = 22'h000000;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000;
  logic hreadyout, hresp, wb_req, wb_ack, irq;
  logic [31:0] hrdata, wb_addr, last_addr, wb_count, st;
  int fails = 0;
  int checks_done = 0;
  logic priv_bit = 1'b0;

  // 100 MHz clock
  always #5 hclk = ~hclk;

  clfu_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .mark_dirty(mark_dirty), .mark_line(mark_line),
    .fill_valid(fill_valid), .fill_line(fill_line), .fill_tag(fill_tag),
    .fault_in(fault_in), .wb_req(wb_req), .wb_addr(wb_addr), .wb_ack(wb_ack), .irq(irq));
  clfu_mem_model mem (.hclk(hclk), .hresetn(hresetn), .wb_req(wb_req), .wb_addr(wb_addr),
    .wb_ack(wb_ack), .lat(lat), .last_addr(last_addr), .wb_count(wb_count));

  task automatic end_of_test;
    $display("checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one bus phase: ends at the edge where hready is sampled high, bounded
  task automatic phase;
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 16);
    if (hreadyout !== 1'b1)
    begin
      fails++;
      end_of_test();
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] o, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h000000, o};
    htrans <= clfu_pkg::HTRANS_NSQ;
    hwrite <= w;
    phase();
    hsel <= 1'b0;
    htrans <= clfu_pkg::HTRANS_IDLE;
    hwdata <= d;
    phase();
    st = hrdata; // read data taken at the closing edge
  endtask

  task automatic rdc(input logic [7:0] o, input logic [31:0] e);
    bus(1'b0, o, 32'h0000_0000);
    chk(st, e);
  endtask

  // load a line tag, optionally dirty it with a processor store
  task automatic prime(input logic [5:0] l, input logic [21:0] t, input logic d);
    @(posedge hclk);
    fill_valid <= 1'b1;
    fill_line <= l;
    fill_tag <= t;
    @(posedge hclk);
    fill_valid <= 1'b0;
    mark_dirty <= d;
    mark_line <= l;
    @(posedge hclk);
    mark_dirty <= 1'b0;
  endtask

  // start one flush, wait for the interrupt, then read and clear the status
  task automatic flush(input clfu_pkg::clfu_op_t op, input logic [31:0] b, input logic [15:0] f);
    int n;
    bus(1'b1, clfu_pkg::OFF_BASE, b);
    bus(1'b1, clfu_pkg::OFF_OFFS, {16'h0000, f});
    bus(1'b1, clfu_pkg::OFF_CTRL, {28'h0, priv_bit, op, 1'b1});
    n = 0;
    while (irq !== 1'b1 && n < 64)
    begin
      @(posedge hclk);
      n++;
    end
    if (irq !== 1'b1)
    begin
      fails++;
      end_of_test();
    end
    bus(1'b0, clfu_pkg::OFF_IRQS, 32'h0000_0000);
  endtask

  // ==========
  // main sequence
  initial
  begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    rdc(clfu_pkg::OFF_STAT, 32'h0);
    rdc(clfu_pkg::OFF_CFG, 32'h3);
    rdc(8'h3C, 32'h0);
    chk({30'h0, hreadyout, hresp}, 32'h2);
    bus(1'b1, clfu_pkg::OFF_MASK, 32'h3);
    $display("test reset done");
    // negative offset; write-back address rebuilt from the stored tag
    prime(6'h3F, 22'h5, 1'b1);
    flush(clfu_pkg::OP_DLINE, 32'h1000, 16'hFFF0);
    chk(st, 32'h5);
    chk(last_addr, 32'h17F0);
    rdc(clfu_pkg::OFF_EA, 32'h0FF0);
    flush(clfu_pkg::OP_DLINE, 32'h1000, 16'hFFF0);
    chk(st, 32'h1);
    prime(6'h3F, 22'h5, 1'b0);
    flush(clfu_pkg::OP_DLINE, 32'h17F0, 16'h0000);
    chk(wb_count, 32'h1);
    $display("test index done");
    // tag miss first, then a hit answered slowly by memory
    prime(6'h3F, 22'h5, 1'b1);
    flush(clfu_pkg::OP_DADDR, 32'h1000, 16'hFFF0);
    chk(st, 32'h1);
    lat <= 4'h5;
    flush(clfu_pkg::OP_DADDR, 32'h1000, 16'h07F0);
    chk(st, 32'h5);
    chk(wb_count, 32'h2);
    chk(last_addr, 32'h17F0);
    flush(clfu_pkg::OP_DADDR, 32'h1000, 16'h07F0);
    chk(wb_count, 32'h2);
    $display("test tagged done");
    // every fault kind on the tag-checked flush, none on the index flush
    prime(6'h3F, 22'h5, 1'b0);
    for (int i = 0; i < 4; i++)
    begin
      fault_in <= 4'h1 << i;
      flush(clfu_pkg::OP_DADDR, 32'h17F0, 16'h0000);
      chk({31'h0, st[clfu_pkg::IRQ_EXC]}, 32'h1);
      rdc(clfu_pkg::OFF_FAULT, 32'h1 << i);
    end
    flush(clfu_pkg::OP_DLINE, 32'h17F0, 16'h0000);
    chk({31'h0, st[clfu_pkg::IRQ_EXC]}, 32'h0);
    fault_in <= 4'h0;
    // privilege fault forced through the control word
    priv_bit = 1'b1;
    flush(clfu_pkg::OP_DADDR, 32'h17F0, 16'h0000);
    priv_bit = 1'b0;
    chk(st, 32'h3);
    rdc(clfu_pkg::OFF_FAULT, 32'h1);
    $display("test fault done");
    flush(clfu_pkg::OP_ILINE, 32'h1230, 16'h0000);
    chk(st, 32'h1);
    rdc(clfu_pkg::OFF_LINE, 32'h23);
    chk(wb_count, 32'h2);
    $display("test icache done");
    end_of_test();
  end
endmodule
